// ---- bench/remote_ctrl.sv ----
// Remote controller model: turns bench commands into request pulses
`default_nettype none
module remote_ctrl (
    input wire logic open_cmd,
    input wire logic msg_cmd,
    input wire logic clear_cmd,
    output logic conn_req,
    output logic msg_valid,
    output logic msg_is_reset
);
    timeunit 1ns;
    timeprecision 100ps;
    // New configuration only lands through a fresh open
    assign conn_req = open_cmd;
    // The program may clear the latched fault by the reset service
    assign msg_valid = msg_cmd | clear_cmd;
    assign msg_is_reset = clear_cmd;
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the overload supervisor
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int GRACE = 20;
    localparam int FLASH = 4;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic overload = 1'b0;
    logic open_cmd = 1'b0;
    logic msg_cmd = 1'b0;
    logic clear_cmd = 1'b0;
    logic conn_req, msg_valid, msg_is_reset, msg_ready, msg_taken, conn_ans_valid;
    logic conn_granted, drop_all, conn_allowed, status_red, status_green, red;
    logic [7:0] conn_status;
    int fails = 0;
    int samples_checked = 0;
    int n;
    int drops;
    always #4 clk = ~clk;
    remote_ctrl ctrl (.open_cmd(open_cmd), .msg_cmd(msg_cmd), .clear_cmd(clear_cmd),
        .conn_req(conn_req), .msg_valid(msg_valid), .msg_is_reset(msg_is_reset));
    adapter_overload_supervisor #(.GRACE_CYCLES(GRACE), .FLASH_CYCLES(FLASH)) dut (
        .clk(clk), .nrst(nrst), .overload(overload), .conn_req(conn_req),
        .msg_valid(msg_valid), .msg_is_reset(msg_is_reset), .msg_ready(msg_ready),
        .msg_taken(msg_taken), .conn_ans_valid(conn_ans_valid), .conn_granted(conn_granted),
        .conn_status(conn_status), .drop_all(drop_all), .conn_allowed(conn_allowed),
        .status_red(status_red), .status_green(status_green));
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic connect(input logic [7:0] st, input logic gr);
        open_cmd = 1'b1;
        tick(1);
        open_cmd = 1'b0;
        chk(8'(conn_ans_valid), 8'h01);
        chk(8'(conn_granted), 8'(gr));
        chk(conn_status, st);
        tick(1);
        chk(8'(conn_ans_valid), 8'h00);
    endtask
    task automatic message(input logic rst);
        clear_cmd = rst;
        msg_cmd = ~rst;
        tick(1);
        clear_cmd = 1'b0;
        msg_cmd = 1'b0;
        chk(8'(msg_taken), 8'h01);
        tick(1);
    endtask
    // Counts lock entries over k cycles with the overload input held at lvl
    task automatic run(input logic lvl, input int k);
        overload = lvl;
        repeat (k)
        begin
            tick(1);
            drops += drop_all;
        end
    endtask
    task automatic finish_test;
        $display("checks=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_short;
        drops = 0;
        // Two bursts together exceed the grace period, each alone does not
        repeat (2)
        begin
            run(1'b1, GRACE - 6);
            run(1'b0, 4);
        end
        chk(8'(drops), 8'h00);
        chk(8'(conn_allowed), 8'h01);
        connect(8'h00, 1'b1);
    endtask
    task automatic t_lock;
        overload = 1'b1;
        n = 0;
        while (drop_all !== 1'b1 && n < GRACE + 10)
        begin
            tick(1);
            n++;
        end
        chk(8'(n >= GRACE && n <= GRACE + 5), 8'h01);
        chk(8'(drop_all), 8'h01);
        chk(8'(conn_allowed), 8'h00);
        chk(8'(status_green), 8'h00);
    endtask
    task automatic t_refuse;
        drops = 0;
        run(1'b0, 4);
        connect(8'h0c, 1'b0);
        connect(8'h0c, 1'b0);
        red = status_red;
        tick(FLASH);
        chk(8'(status_red), {7'h00, ~red});
        run(1'b1, GRACE + 8);
        run(1'b0, 6);
        chk(8'(drops), 8'h00);
        chk(8'(conn_allowed), 8'h00);
        message(1'b0);
        chk(8'(conn_allowed), 8'h00);
        message(1'b1);
        chk(8'(conn_allowed), 8'h01);
        connect(8'h00, 1'b1);
    endtask
    initial
    begin
        #20000;
        fails++;
        finish_test();
    end
    initial
    begin
        tick(3);
        nrst = 1'b1;
        chk(8'(status_green), 8'h01);
        chk(8'(msg_ready), 8'h01);
        t_short();
        t_lock();
        t_refuse();
        finish_test();
    end
endmodule
`default_nettype wire

// ---- design/adapter_overload_supervisor.sv ----
// Overload supervisor: grace timer, latched no-connections state, refusal and indicator
`include "overload_defines.svh"
`default_nettype none
module adapter_overload_supervisor #(
    parameter int GRACE_CYCLES = `GRACE_CYCLES,
    parameter int FLASH_CYCLES = `FLASH_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic overload,
    input wire logic conn_req,
    input wire logic msg_valid,
    input wire logic msg_is_reset,
    output logic msg_ready,
    output logic msg_taken,
    output logic conn_ans_valid,
    output logic conn_granted,
    output logic [7:0] conn_status,
    output logic drop_all,
    output logic conn_allowed,
    output logic status_red,
    output logic status_green
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic ov_s1;
        logic ov_s2;
        overload_pkg::mode_t mode;
        logic [31:0] grace_cnt;
        logic [31:0] flash_cnt;
        logic flash_on;
        logic ans_valid;
        logic granted;
        logic [7:0] status;
        logic drop;
        logic taken;
    } state_t;

    state_t s;
    state_t next_s;

    // A span of lim cycles ends when the count reaches lim - 1
    function automatic logic cnt_done(input logic [31:0] c, input int lim);
        cnt_done = (c >= 32'(lim - 1));
    endfunction

    always_comb
    begin
        next_s = s;
        // Overload is an outside level, so it is synchronised first
        next_s.ov_s1 = overload;
        next_s.ov_s2 = s.ov_s1;
        next_s.drop = 1'b0;
        next_s.ans_valid = 1'b0;
        next_s.taken = 1'b0;
        case (s.mode)
            overload_pkg::st_normal:
            begin
                next_s.grace_cnt = '0;
                if (s.ov_s2)
                begin
                    next_s.mode = overload_pkg::st_grace;
                end
            end
            overload_pkg::st_grace:
            begin
                // Any gap restarts the count, so only a continuous overload locks
                if (!s.ov_s2)
                begin
                    next_s.mode = overload_pkg::st_normal;
                    next_s.grace_cnt = '0;
                end
                else if (cnt_done(s.grace_cnt, GRACE_CYCLES))
                begin
                    next_s.mode = overload_pkg::st_locked;
                    next_s.drop = 1'b1;
                    next_s.flash_cnt = '0;
                    next_s.flash_on = 1'b1;
                end
                else
                begin
                    next_s.grace_cnt = s.grace_cnt + 32'h1;
                end
            end
            overload_pkg::st_locked:
            begin
                // Latched, so no second drop: only a reset service releases it
                if (cnt_done(s.flash_cnt, FLASH_CYCLES))
                begin
                    next_s.flash_cnt = '0;
                    next_s.flash_on = !s.flash_on;
                end
                else
                begin
                    next_s.flash_cnt = s.flash_cnt + 32'h1;
                end
                if (msg_valid && msg_is_reset)
                begin
                    next_s.mode = overload_pkg::st_normal;
                    next_s.grace_cnt = '0;
                end
            end
            default:
            begin
                next_s.mode = overload_pkg::st_normal;
            end
        endcase
        if (msg_valid)
        begin
            next_s.taken = 1'b1;
        end
        // A request is judged on the mode before this edge; one at lock entry is granted
        if (conn_req)
        begin
            next_s.ans_valid = 1'b1;
            if (s.mode == overload_pkg::st_locked)
            begin
                next_s.granted = 1'b0;
                next_s.status = `STATUS_OVERLOAD;
            end
            else
            begin
                next_s.granted = 1'b1;
                next_s.status = `STATUS_SUCCESS;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Messages are never stalled, so a reset service always reaches the block
    assign msg_ready = 1'b1;
    assign msg_taken = s.taken;
    assign conn_ans_valid = s.ans_valid;
    assign conn_granted = s.granted;
    assign conn_status = s.status;
    assign drop_all = s.drop;
    assign conn_allowed = (s.mode != overload_pkg::st_locked);
    assign status_red = (s.mode == overload_pkg::st_locked) && s.flash_on;
    assign status_green = (s.mode != overload_pkg::st_locked);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_refuse_locked: assert property (@(posedge clk) disable iff (!nrst)
        (conn_req && s.mode == overload_pkg::st_locked) |=> (conn_ans_valid && !conn_granted
        && conn_status == 8'h0c))
        else $error("connection not refused with overload status");
    a_latch_holds: assert property (@(posedge clk) disable iff (!nrst)
        (s.mode == overload_pkg::st_locked && !(msg_valid && msg_is_reset))
        |=> s.mode == overload_pkg::st_locked)
        else $error("overload latch released without reset service");
    a_reset_leaves: assert property (@(posedge clk) disable iff (!nrst)
        (s.mode == overload_pkg::st_locked && msg_valid && msg_is_reset) |=> conn_allowed)
        else $error("reset service did not leave locked state");
    a_drop_on_lock: assert property (@(posedge clk) disable iff (!nrst)
        $rose(s.mode == overload_pkg::st_locked) |-> drop_all)
        else $error("lock without drop of connections");
    a_drop_once: assert property (@(posedge clk) disable iff (!nrst)
        drop_all |=> !drop_all)
        else $error("connections dropped repeatedly");
    a_grace_restart: assert property (@(posedge clk) disable iff (!nrst)
        (s.mode == overload_pkg::st_grace && !s.ov_s2) |=> s.grace_cnt == 32'h0)
        else $error("grace timer not restarted");
    a_msg_served: assert property (@(posedge clk) disable iff (!nrst)
        msg_valid |=> msg_taken)
        else $error("message not taken");
    a_red_only_lock: assert property (@(posedge clk) disable iff (!nrst)
        status_red |-> !conn_allowed)
        else $error("red indicator outside overload state");
    a_no_early_drop: assert property (@(posedge clk) disable iff (!nrst)
        drop_all |-> $past(s.grace_cnt) == 32'(GRACE_CYCLES - 1))
        else $error("drop before grace period ended");
    a_grace_counts: assert property (@(posedge clk) disable iff (!nrst)
        (s.mode == overload_pkg::st_grace && s.ov_s2 && s.grace_cnt < 32'(GRACE_CYCLES - 1))
        |=> (s.mode == overload_pkg::st_grace && s.grace_cnt == $past(s.grace_cnt) + 32'h1))
        else $error("grace timer did not advance under overload");
    a_lock_after_grace: assert property (@(posedge clk) disable iff (!nrst)
        $rose(s.mode == overload_pkg::st_locked)
        |-> $past(s.mode == overload_pkg::st_grace && s.ov_s2))
        else $error("locked without a grace period under overload");
    a_grant_free: assert property (@(posedge clk) disable iff (!nrst)
        (conn_req && s.mode != overload_pkg::st_locked) |=> (conn_ans_valid && conn_granted
        && conn_status == 8'h00))
        else $error("connection refused outside overload state");
    a_answer_paired: assert property (@(posedge clk) disable iff (!nrst)
        conn_ans_valid |-> $past(conn_req))
        else $error("connection answer without request");
    a_red_on_entry: assert property (@(posedge clk) disable iff (!nrst)
        $rose(s.mode == overload_pkg::st_locked) |-> status_red)
        else $error("red indicator not lit on overload");
    a_red_toggles: assert property (@(posedge clk) disable iff (!nrst)
        (s.mode == overload_pkg::st_locked && s.flash_cnt >= 32'(FLASH_CYCLES - 1)
        && !(msg_valid && msg_is_reset)) |=> status_red != $past(status_red))
        else $error("red indicator did not flash");
    a_red_steady: assert property (@(posedge clk) disable iff (!nrst)
        (s.mode == overload_pkg::st_locked && s.flash_cnt < 32'(FLASH_CYCLES - 1)
        && !(msg_valid && msg_is_reset)) |=> $stable(status_red))
        else $error("red indicator changed between flash steps");
    a_taken_pulse: assert property (@(posedge clk) disable iff (!nrst)
        !msg_valid |=> !msg_taken)
        else $error("message taken without a message");
    a_drop_from_grace: assert property (@(posedge clk) disable iff (!nrst)
        drop_all |-> $past(s.mode == overload_pkg::st_grace))
        else $error("connections dropped outside lock entry");
    a_grace_idle_zero: assert property (@(posedge clk) disable iff (!nrst)
        (s.mode == overload_pkg::st_normal) |=> s.grace_cnt == 32'h0)
        else $error("grace timer not cleared while idle");
endmodule
`default_nettype wire

// ---- design/overload_defines.svh ----
// Constants for the adapter overload supervisor
// How it works
// - Overload is tolerated for a 2.5 s grace period, and only overload lasting beyond it drops the backplane connections.
// - Once the block decides it is overloaded, it removes every network connection and enters the no-connections state.
// - In the no-connections state every connection request is answered with general status 0x0c.
// - While the overload state is active, the module status indicator flashes red.
// - In the no-connections state, explicit messages are still accepted and processed.
// - A module reset service received in the no-connections state makes the block leave that state.
// - The overload error is latched, and connections stay refused until a module reset service, even after the overload ends.
// - While overloaded the block holds one steady refused state and does not make and drop connections over and over.
`ifndef OVERLOAD_DEFINES_SVH
`define OVERLOAD_DEFINES_SVH
`define GRACE_MS 2500
`define CLK_KHZ 125000
`define GRACE_CYCLES (`GRACE_MS * `CLK_KHZ)
`define FLASH_MS 500
`define FLASH_CYCLES (`FLASH_MS * `CLK_KHZ)
`define STATUS_SUCCESS 8'h00
`define STATUS_OVERLOAD 8'h0c
`endif

// ---- design/overload_pkg.sv ----
// Types for the adapter overload supervisor
`default_nettype none
package overload_pkg;
    typedef enum logic [1:0] {
        st_normal = 2'b00,
        st_grace = 2'b01,
        st_locked = 2'b11
    } mode_t;
endpackage
`default_nettype wire
